// ### iso_rx_mask_fairness_link_ctrl.sv
// receive irq mask, fairness limit and link control flags with cycle timer
// Functional notes
// - summary irq asserts only for events of channels whose enable bit is one
// - mask written via set and clear addresses; both read back the mask
// - channel enables in bits 3..0 aligned to event bits; upper bits zero
// - eight-bit field limits priority arbitration requests per fairness interval
// - fairness bits 31..8 ignore writes and read zero
// - fairness register at its own offset, resets to zero
// - link flags written through separate set and clear addresses
// - flags at 22,21,20,10,9; others read zero
// - rollover from external input when selected, else every 3072 ticks
// - cycle master sends start on rollover when root; overrun clears it
// - cycle offset counts and rolls only while count enable set
// - flags 10 and 9 accept phy packets and self-id packets
module iso_rx_mask_fairness_link_ctrl
    import link_regs_pkg::*;
#(
    parameter int CHANNELS = RX_CHANNELS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire link_regs_pkg::reg_req_t req,
    output logic [31:0] rdata,
    output logic rdata_valid,
    input wire logic [CHANNELS-1:0] rx_event,
    input wire logic cycle_overrun_flag,
    input wire logic phy_is_root,
    input wire logic external_cycle_input,
    input wire logic link_tick,
    output logic iso_receive_summary_irq,
    output logic [7:0] priority_request_limit,
    output link_regs_pkg::link_flags_t flags,
    output logic [CYCLE_W-1:0] cycle_offset,
    output logic cycle_start_send
);
    import link_regs_pkg::*;

    logic [CHANNELS-1:0] mask;
    logic [FAIR_W-1:0] fairness;
    logic cyc_s1, cyc_s2, cyc_s3;
    logic roll;
    logic [31:0] next_rdata;

    wire wr_mask_set = req.wr && req.addr == OFS_IRQ_ENABLE_SET;
    wire wr_mask_clr = req.wr && req.addr == OFS_IRQ_ENABLE_CLEAR;
    wire wr_link_set = req.wr && req.addr == OFS_LINK_SET;
    wire wr_link_clr = req.wr && req.addr == OFS_LINK_CLEAR;

    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : g_mask
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mask[i] <= MASK_RESET[0];
                end else if (wr_mask_set && req.wdata[i]) begin
                    mask[i] <= 1'b1;
                end else if (wr_mask_clr && req.wdata[i]) begin
                    mask[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            iso_receive_summary_irq <= 1'b0;
        end else begin
            iso_receive_summary_irq <= |(rx_event & mask);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fairness <= FAIRNESS_RESET;
        end else if (req.wr && req.addr == OFS_FAIRNESS) begin
            fairness <= req.wdata[FAIR_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            priority_request_limit <= FAIRNESS_RESET;
        end else begin
            priority_request_limit <= fairness;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= '{default: FLAG_RESET};
        end else begin
            if (wr_link_set && req.wdata[BIT_ROLL_SRC]) begin
                flags.rollover_source_select <= 1'b1;
            end else if (wr_link_clr && req.wdata[BIT_ROLL_SRC]) begin
                flags.rollover_source_select <= 1'b0;
            end
            if (wr_link_set && req.wdata[BIT_CYC_COUNT]) begin
                flags.cycle_offset_count_enable <= 1'b1;
            end else if (wr_link_clr && req.wdata[BIT_CYC_COUNT]) begin
                flags.cycle_offset_count_enable <= 1'b0;
            end
            if (wr_link_set && req.wdata[BIT_PHY_PKT]) begin
                flags.accept_phy_layer_packets <= 1'b1;
            end else if (wr_link_clr && req.wdata[BIT_PHY_PKT]) begin
                flags.accept_phy_layer_packets <= 1'b0;
            end
            if (wr_link_set && req.wdata[BIT_SELF_ID]) begin
                flags.accept_self_id_packets <= 1'b1;
            end else if (wr_link_clr && req.wdata[BIT_SELF_ID]) begin
                flags.accept_self_id_packets <= 1'b0;
            end
            // overrun clears master; hardware clear beats software set
            if (cycle_overrun_flag) begin
                flags.cycle_start_generator_enable <= 1'b0;
            end else if (wr_link_set && req.wdata[BIT_CYC_MASTER]) begin
                flags.cycle_start_generator_enable <= 1'b1;
            end else if (wr_link_clr && req.wdata[BIT_CYC_MASTER]) begin
                flags.cycle_start_generator_enable <= 1'b0;
            end
        end
    end

    // external input is asynchronous; third stage is only for edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cyc_s1 <= 1'b0;
            cyc_s2 <= 1'b0;
            cyc_s3 <= 1'b0;
        end else begin
            cyc_s1 <= external_cycle_input;
            cyc_s2 <= cyc_s1;
            cyc_s3 <= cyc_s2;
        end
    end

    always_comb begin
        if (!flags.cycle_offset_count_enable) begin
            roll = 1'b0;
        end else if (flags.rollover_source_select) begin
            roll = cyc_s2 && !cyc_s3;
        end else begin
            roll = link_tick && cycle_offset == CYCLE_W'(CYCLE_TICKS - 1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycle_offset <= '0;
        end else if (roll) begin
            cycle_offset <= '0;
        end else if (flags.cycle_offset_count_enable && link_tick
                     && cycle_offset != CYCLE_W'(CYCLE_TICKS - 1)) begin
            cycle_offset <= cycle_offset + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycle_start_send <= 1'b0;
        end else begin
            cycle_start_send <= roll && flags.cycle_start_generator_enable && phy_is_root;
        end
    end

    always_comb begin
        next_rdata = '0;
        case (req.addr)
            OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLEAR: next_rdata[CHANNELS-1:0] = mask;
            OFS_FAIRNESS: next_rdata[FAIR_W-1:0] = fairness;
            OFS_LINK_SET, OFS_LINK_CLEAR: begin
                next_rdata[BIT_ROLL_SRC] = flags.rollover_source_select;
                next_rdata[BIT_CYC_MASTER] = flags.cycle_start_generator_enable;
                next_rdata[BIT_CYC_COUNT] = flags.cycle_offset_count_enable;
                next_rdata[BIT_PHY_PKT] = flags.accept_phy_layer_packets;
                next_rdata[BIT_SELF_ID] = flags.accept_self_id_packets;
            end
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= '0;
            rdata_valid <= 1'b0;
        end else begin
            rdata <= req.rd ? next_rdata : '0;
            rdata_valid <= req.rd;
        end
    end

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> iso_receive_summary_irq == $past(|(rx_event & mask));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by mask");

    property p_mask_set;
        @(posedge clk) disable iff (!rst_n)
        (wr_mask_set && req.wdata[0]) |=> mask[0];
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask set failed");

    property p_mask_clr;
        @(posedge clk) disable iff (!rst_n)
        (wr_mask_clr && req.wdata[0] && !wr_mask_set) |=> !mask[0];
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask clear failed");

    property p_mask_read;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == OFS_IRQ_ENABLE_CLEAR) |=> rdata[31:CHANNELS] == '0;
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask upper bits set");

    property p_fair_read;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == OFS_FAIRNESS) |=> rdata[31:FAIR_W] == '0;
    endproperty
    a_fair_read: assert property (p_fair_read) else $error("fairness reserved bits");

    property p_fair_wr;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == OFS_FAIRNESS) |=> ##1 priority_request_limit == $past(req.wdata[7:0], 2);
    endproperty
    a_fair_wr: assert property (p_fair_wr) else $error("fairness limit wrong");

    property p_overrun;
        @(posedge clk) disable iff (!rst_n)
        cycle_overrun_flag |=> !flags.cycle_start_generator_enable;
    endproperty
    a_overrun: assert property (p_overrun) else $error("master not cleared");

    property p_halt;
        @(posedge clk) disable iff (!rst_n)
        !flags.cycle_offset_count_enable |=> $stable(cycle_offset);
    endproperty
    a_halt: assert property (p_halt) else $error("offset moved while off");

    property p_link_rd;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == OFS_LINK_SET) |=> rdata[8:0] == '0 && rdata[31:23] == '0;
    endproperty
    a_link_rd: assert property (p_link_rd) else $error("link reserved bits");

    c_irq: cover property (@(posedge clk) iso_receive_summary_irq);
    c_start: cover property (@(posedge clk) cycle_start_send);
    c_roll: cover property (@(posedge clk) roll && !flags.rollover_source_select);
endmodule : iso_rx_mask_fairness_link_ctrl

// ### link_regs_pkg.sv
// constants and carriers for the receive-mask, fairness and link control slice
package link_regs_pkg;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'hA8;
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'hAC;
    localparam logic [7:0] OFS_FAIRNESS = 8'hDC;
    localparam logic [7:0] OFS_LINK_SET = 8'hE0;
    localparam logic [7:0] OFS_LINK_CLEAR = 8'hE4;
    localparam int RX_CHANNELS = 4;
    localparam int FAIR_W = 8;
    localparam logic [7:0] FAIRNESS_RESET = 8'h00;
    localparam int BIT_ROLL_SRC = 22;
    localparam int BIT_CYC_MASTER = 21;
    localparam int BIT_CYC_COUNT = 20;
    localparam int BIT_PHY_PKT = 10;
    localparam int BIT_SELF_ID = 9;
    // flag bits are undefined at reset; we choose zero
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam int LINK_CLK_KHZ = 24576;
    localparam int CYCLE_PERIOD_NS = 125000;
    localparam int CYCLE_TICKS = (CYCLE_PERIOD_NS / 1000) * LINK_CLK_KHZ / 1000;
    localparam int CYCLE_W = 12;

    typedef struct packed {
        logic rollover_source_select;
        logic cycle_start_generator_enable;
        logic cycle_offset_count_enable;
        logic accept_phy_layer_packets;
        logic accept_self_id_packets;
    } link_flags_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage : link_regs_pkg

// ### phy_link_model.sv
// partner model: link-rate tick source and external cycle input pulser
module phy_link_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_go,
    output logic link_tick,
    output logic external_cycle_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div;
    logic [2:0] hold;
    // link rate ticks
    // ten fast cycles per tick, near the link rate
    always_ff @(posedge clk) begin
        div <= (!rst_n || div == 4'h9) ? 4'h0 : div + 4'h1;
        link_tick <= rst_n && div == 4'h9;
    end
    // external cycle edge
    // held several cycles so the two-flop sync cannot miss it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold <= 3'h0;
        end else if (ext_go) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
        external_cycle_input <= hold != 3'h0;
    end
endmodule : phy_link_model

// ### iso_rx_mask_fairness_link_ctrl_tb.sv
// self-checking bench for the receive mask, fairness and link control slice
module iso_rx_mask_fairness_link_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import link_regs_pkg::*;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] exp;
    } row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req = '0;
    logic [3:0] rx_event = 4'h0;
    logic ovr = 1'b0;
    logic root = 1'b0;
    logic ext_go = 1'b0;
    logic link_tick;
    logic ext_in;
    logic [31:0] rdata;
    logic rdata_valid;
    logic irq;
    logic [7:0] prl;
    link_flags_t flags;
    logic [CYCLE_W-1:0] cyc_ofs;
    logic [CYCLE_W-1:0] ofs_hold;
    logic start;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    row_t rows [6] = '{
        '{8'hA8, 32'hFFFFFFFF, 8'hAC, 32'h0000000F},
        '{8'hAC, 32'h00000005, 8'hA8, 32'h0000000A},
        '{8'hDC, 32'hFFFFFF5A, 8'hDC, 32'h0000005A},
        '{8'hE0, 32'hFFFFFFFF, 8'hE4, 32'h00700600},
        '{8'hE4, 32'h00100200, 8'hE0, 32'h00600400},
        '{8'h40, 32'hFFFFFFFF, 8'h40, 32'h00000000}
    };
    iso_rx_mask_fairness_link_ctrl #(.CHANNELS(RX_CHANNELS)) u_dut (
        .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rdata_valid(rdata_valid),
        .rx_event(rx_event), .cycle_overrun_flag(ovr), .phy_is_root(root),
        .external_cycle_input(ext_in), .link_tick(link_tick),
        .iso_receive_summary_irq(irq), .priority_request_limit(prl), .flags(flags),
        .cycle_offset(cyc_ofs), .cycle_start_send(start)
    );
    phy_link_model u_phy (
        .clk(clk), .rst_n(rst_n), .ext_go(ext_go), .link_tick(link_tick),
        .external_cycle_input(ext_in)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic end_sim();
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(negedge clk);
        req <= '0;
        chk(rdata, exp);
        chk({31'h0, rdata_valid}, 32'h1);
    endtask : rd
    // pulse is one cycle wide, so it is looked at every cycle
    task automatic wait_start(input int lim);
        n = 0;
        while (start !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask : wait_start
    // hang guard, well above the two full cycle periods
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
        rd(OFS_FAIRNESS, 32'h0);
        rd(OFS_LINK_SET, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].exp);
        end
        rx_event <= 4'h5;
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rx_event <= 4'h2;
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        chk({24'h0, prl}, 32'h5A);
        wr(OFS_LINK_SET, 32'h00100200);
        // first pulse while not root must give no start packet
        for (int k = 0; k < 2; k++) begin
            root <= k[0];
            ext_go <= 1'b1;
            @(negedge clk);
            ext_go <= 1'b0;
            wait_start(12);
            chk({31'h0, n < 12}, {31'h0, k[0]});
        end
        wr(OFS_LINK_CLEAR, 32'h00400000);
        chk({27'h0, flags}, 32'h0F);
        wait_start(40000);
        wait_start(40000);
        chk({31'h0, n > 30700 && n < 30740}, 32'h1);
        wr(OFS_LINK_CLEAR, 32'h00100000);
        ofs_hold = cyc_ofs;
        repeat (40) @(negedge clk);
        chk({20'h0, cyc_ofs}, {20'h0, ofs_hold});
        ovr <= 1'b1;
        repeat (2) @(negedge clk);
        wr(OFS_LINK_SET, 32'h00200000);
        rd(OFS_LINK_SET, 32'h00000600);
        // mid-run reset brings every register back to zero
        rst_n <= 1'b0;
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
        rd(OFS_IRQ_ENABLE_SET, 32'h0);
        rd(OFS_FAIRNESS, 32'h0);
        chk({24'h0, prl}, 32'h0);
        chk({27'h0, flags}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule : iso_rx_mask_fairness_link_ctrl_tb
